// file: verilog/sms_pkg.sv
// Shared constants and types of the stepper axis mode sequencer
`default_nettype none
package sms_pkg;
   // Mode selection word values
   localparam logic [15:0] MODE_OFF    = 16'h0000;
   localparam logic [15:0] MODE_DIRECT = 16'h0001;
   localparam logic [15:0] MODE_MANUAL = 16'h0002;
   // Clock and ramp timing
   localparam int          CLK_HZ       = 40_000_000;
   localparam int          CLK_NS       = 25;
   localparam int          RAMP_TICK_NS = 1_000_000;
   localparam int          RAMP_TICK_CYC = RAMP_TICK_NS / CLK_NS;
   // Speed coefficient is unsigned 8.8 fixed point
   localparam int          COEF_SHIFT = 8;
   // Fault type word codes: low byte commands, high byte parameters
   localparam logic [15:0] FLT_NONE  = 16'h0000;
   localparam logic [15:0] FLT_COND  = 16'h0001;
   localparam logic [15:0] FLT_UNREF = 16'h0002;
   localparam logic [15:0] FLT_LIMIT = 16'h0004;
   localparam logic [15:0] FLT_MODE  = 16'h0008;
   localparam logic [15:0] FLT_SHARED_DWORD_A = 16'h0100;
   // Operating mode, with a transit state while the axis comes to rest
   typedef enum logic [3:0] {
      SMS_OFF    = 4'b0001,
      SMS_MANUAL = 4'b0010,
      SMS_DIRECT = 4'b0100,
      SMS_SWITCH = 4'b1000
   } sms_mode_t;
   // Kind of motion in progress
   typedef enum logic [4:0] {
      MV_NONE = 5'b00001,
      MV_JOG  = 5'b00010,
      MV_INC  = 5'b00100,
      MV_HOME = 5'b01000,
      MV_DIR  = 5'b10000
   } sms_move_t;
endpackage
`default_nettype wire

// file: verilog/sms_axis_seq.sv
// Mode sequencer and pulse generator for one stepper axis
`default_nettype none
module sms_axis_seq #(
   parameter int FW       = 24,
   parameter int PW       = 32,
   parameter int TICK_CYC = sms_pkg::RAMP_TICK_CYC
) (
   input  wire logic                 i_ref_clk,
   input  wire logic                 i_reset,
   input  wire logic [15:0]          i_mode_sel,
   input  wire logic                 i_plc_stop,
   input  wire logic                 i_config_load,
   input  wire logic                 i_jog_plus_cmd,
   input  wire logic                 i_jog_minus_cmd,
   input  wire logic                 i_inc_plus_cmd,
   input  wire logic                 i_inc_minus_cmd,
   input  wire logic                 i_homing_move_cmd,
   input  wire logic                 i_forced_home_cmd,
   input  wire logic                 i_direct_drive_cmd,
   input  wire logic                 i_stop_cmd,
   input  wire logic                 i_enable_cmd,
   input  wire logic                 i_fault_ack,
   input  wire logic                 i_block_fault,
   input  wire logic                 i_limit_plus,
   input  wire logic                 i_limit_minus,
   input  wire logic                 i_home_switch,
   input  wire logic                 i_home_dir,
   input  wire logic [FW-1:0]        i_manual_speed,
   input  wire logic [15:0]          i_speed_scale_coef,
   input  wire logic [FW-1:0]        i_max_axis_freq,
   input  wire logic [FW-1:0]        i_start_stop_freq,
   input  wire logic [FW-1:0]        i_accel_step,
   input  wire logic signed [PW-1:0] i_shared_dword_a,
   input  wire logic signed [PW-1:0] i_home_value,
   input  wire logic signed [PW-1:0] i_soft_lim_hi,
   input  wire logic signed [PW-1:0] i_soft_lim_lo,
   output logic                      o_translator_enable,
   output logic                      o_step,
   output logic                      o_dir,
   output logic [FW-1:0]             o_step_freq,
   output logic signed [PW-1:0]      o_position,
   output logic                      o_done,
   output logic                      o_referenced,
   output logic                      o_axis_no_block_fault,
   output logic                      o_soft_lim_fault,
   output logic                      o_manual_mode_active,
   output logic                      o_direct_mode_active,
   output logic                      o_direct_motion_busy,
   output logic                      o_cmd_refused_flag,
   output logic [15:0]               o_cmd_fault_type
);
   localparam logic [26:0] CLK_HZ_W = 27'(sms_pkg::CLK_HZ);

   sms_pkg::sms_mode_t st, pend;
   sms_pkg::sms_move_t mv;
   logic [6:0]           cmd_q;
   logic                 en_q, out_q;
   logic [26:0]          phase;
   logic [31:0]          tick_cnt;
   logic signed [PW-1:0] inc_target;
   // Command edges; a bit already high on mode entry never shows an edge
   wire [6:0] cmd_now = {i_direct_drive_cmd, i_forced_home_cmd, i_homing_move_cmd,
                         i_inc_minus_cmd, i_inc_plus_cmd, i_jog_minus_cmd, i_jog_plus_cmd};
   wire [6:0] rise = cmd_now & ~cmd_q;
   wire       rise_man = |rise[5:0];
   wire       tick = (tick_cnt == 32'(TICK_CYC - 1));
   // Requested mode from word, controller stop and configuration
   wire sms_pkg::sms_mode_t req_mode =
      (i_plc_stop || i_config_load) ? sms_pkg::SMS_OFF :
      (i_mode_sel == sms_pkg::MODE_MANUAL) ? sms_pkg::SMS_MANUAL :
      (i_mode_sel == sms_pkg::MODE_DIRECT) ? sms_pkg::SMS_DIRECT : sms_pkg::SMS_OFF;
   wire mode_chg = (st != sms_pkg::SMS_SWITCH) && (req_mode != st);
   wire at_rest  = (mv == sms_pkg::MV_NONE) && (o_step_freq == '0);
   // General acceptance terms
   wire run_ok   = !i_block_fault && !i_stop_cmd && i_enable_cmd;
   wire man_ok   = (st == sms_pkg::SMS_MANUAL) && run_ok && o_done && !mode_chg;
   wire jog_ok   = man_ok && !o_soft_lim_fault;
   wire signed [PW-1:0] inc_tgt_p = o_position + i_shared_dword_a;
   wire signed [PW-1:0] inc_tgt_m = o_position - i_shared_dword_a;
   wire signed [PW-1:0] inc_tgt = rise[2] ? inc_tgt_p : inc_tgt_m;
   wire in_lim_tgt = (inc_tgt <= i_soft_lim_hi) && (inc_tgt >= i_soft_lim_lo);
   wire in_lim_par = (i_shared_dword_a <= i_soft_lim_hi) && (i_shared_dword_a >= i_soft_lim_lo);
   wire inc_ok   = jog_ok && o_referenced && in_lim_tgt;
   wire fh_ok    = jog_ok && in_lim_par;
   // Direct setpoint magnitude and range check
   wire          sp_neg = i_shared_dword_a[PW-1];
   wire [PW-1:0] sp_abs = sp_neg ? PW'(-i_shared_dword_a) : PW'(i_shared_dword_a);
   wire sp_in_rng = (sp_abs >= PW'(i_start_stop_freq)) && (sp_abs <= PW'(i_max_axis_freq));
   wire dir_ok = (st == sms_pkg::SMS_DIRECT) && run_ok && !o_soft_lim_fault
                 && sp_in_rng && at_rest && !mode_chg;
   // Starts and refusals; off and switching modes ignore commands
   wire start_jog = (rise[0] || rise[1]) && jog_ok;
   wire start_inc = (rise[2] || rise[3]) && inc_ok;
   wire start_hom = rise[4] && jog_ok;
   wire start_fh  = rise[5] && fh_ok;
   wire start_dir = rise[6] && dir_ok;
   wire refuse_m  = (st == sms_pkg::SMS_MANUAL) && rise_man
                    && !(start_jog || start_inc || start_hom || start_fh);
   wire refuse_d  = (st == sms_pkg::SMS_DIRECT) && rise[6] && !dir_ok;
   wire refuse_w  = ((st == sms_pkg::SMS_MANUAL) && rise[6])
                    || ((st == sms_pkg::SMS_DIRECT) && rise_man);
   wire refuse    = refuse_m || refuse_d || refuse_w;
   wire accepted  = start_jog || start_inc || start_hom || start_fh || start_dir;
   wire [15:0] flt_code =
      refuse_w ? sms_pkg::FLT_MODE :
      (refuse_d && !sp_in_rng) ? sms_pkg::FLT_SHARED_DWORD_A :
      ((rise[2] || rise[3]) && !o_referenced) ? sms_pkg::FLT_UNREF :
      (((rise[2] || rise[3]) && !in_lim_tgt) || (rise[5] && !in_lim_par)) ?
      sms_pkg::FLT_LIMIT : sms_pkg::FLT_COND;
   // Soft limit monitoring exists only while referenced
   wire out_lim  = o_referenced && ((o_position > i_soft_lim_hi)
                                    || (o_position < i_soft_lim_lo));
   wire soft_hit = out_lim && !out_q;
   wire lim_hit  = (o_dir && i_limit_plus) || (!o_dir && i_limit_minus);
   wire abort    = !run_ok || soft_hit || mode_chg || i_config_load || lim_hit
                   || refuse;
   wire jog_held = o_dir ? i_jog_plus_cmd : i_jog_minus_cmd;
   wire inc_done = o_dir ? (o_position >= inc_target) : (o_position <= inc_target);
   wire home_done = (mv == sms_pkg::MV_HOME) && i_home_switch;
   // Motion end per kind
   wire mv_end =
      abort ||
      ((mv == sms_pkg::MV_JOG) && !jog_held) ||
      ((mv == sms_pkg::MV_INC) && inc_done) ||
      home_done ||
      ((mv == sms_pkg::MV_DIR) && !i_direct_drive_cmd);
   // Speed targets: live coefficient, clamped every cycle
   wire [FW+15:0] man_prod   = i_manual_speed * i_speed_scale_coef;
   wire [FW+15:0] man_scaled = man_prod >> sms_pkg::COEF_SHIFT;
   wire [FW-1:0]  manual_speed = (man_scaled > (FW+16)'(i_max_axis_freq)) ?
                            i_max_axis_freq : man_scaled[FW-1:0];
   wire [FW-1:0]  dir_spd = (sp_abs > PW'(i_max_axis_freq)) ? i_max_axis_freq :
                            (sp_abs < PW'(i_start_stop_freq)) ? i_start_stop_freq :
                            sp_abs[FW-1:0];
   wire sign_flip = (mv == sms_pkg::MV_DIR) && (sp_neg == o_dir);
   wire [FW-1:0]  tgt = (mv == sms_pkg::MV_NONE) ? '0 :
                        (mv == sms_pkg::MV_DIR) ? (sign_flip ? '0 : dir_spd) : manual_speed;
   // Trapezoidal ramp; direct motion starts at or above start-stop frequency and drops below it only at a setpoint sign flip, a refusal or the end of the move
   wire [FW-1:0] up_room = tgt - o_step_freq;
   wire [FW-1:0] dn_room = o_step_freq - tgt;
   wire [FW-1:0] f_up = (up_room > i_accel_step) ? o_step_freq + i_accel_step : tgt;
   wire [FW-1:0] f_dn = (dn_room > i_accel_step) ? o_step_freq - i_accel_step : tgt;
   wire [FW-1:0] f_ramp = (o_step_freq < tgt) ? f_up : f_dn;
   wire          dir_low = (mv == sms_pkg::MV_DIR) && (f_ramp < i_start_stop_freq);
   wire [FW-1:0] f_dir = !dir_low ? f_ramp : (tgt == '0) ? '0 : i_start_stop_freq;
   wire [FW-1:0] f_tick = tick ? f_dir : o_step_freq;
   wire          hard_stop = refuse || ((mv == sms_pkg::MV_INC) && inc_done);
   wire [FW-1:0] next_freq = hard_stop ? '0 :
                             (f_tick > i_max_axis_freq) ? i_max_axis_freq : f_tick;
   // Step phase accumulator; position updates in every mode
   wire [26:0] phase_sum = phase + 27'(o_step_freq);
   wire        step_now  = phase_sum >= CLK_HZ_W;
   wire [26:0] next_phase = step_now ? phase_sum - CLK_HZ_W : phase_sum;
   wire signed [PW-1:0] pos_step = o_dir ? o_position + PW'(1) : o_position - PW'(1);
   wire signed [PW-1:0] next_pos =
      start_fh ? i_shared_dword_a :
      home_done ? i_home_value :
      step_now ? pos_step : o_position;
   // Ramp tick divider
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset) tick_cnt <= '0;
      else tick_cnt <= tick ? '0 : tick_cnt + 32'h0000_0001;
   end
   // Input history for edge detection
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         cmd_q <= '0;
         en_q  <= 1'b0;
         out_q <= 1'b0;
      end
      else
      begin
         cmd_q <= cmd_now;
         en_q  <= i_enable_cmd;
         out_q <= out_lim;
      end
   end
   // Mode sequencing: leave through the switch state until at rest
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         st   <= sms_pkg::SMS_OFF;
         pend <= sms_pkg::SMS_OFF;
      end
      else
      begin
         case (st)
            sms_pkg::SMS_SWITCH:
               if (at_rest) st <= pend;
            sms_pkg::SMS_OFF, sms_pkg::SMS_MANUAL, sms_pkg::SMS_DIRECT:
               if (mode_chg)
               begin
                  st   <= sms_pkg::SMS_SWITCH;
                  pend <= req_mode;
               end
            default: st <= sms_pkg::SMS_OFF;
         endcase
      end
   end
   // Motion kind, direction and increment target
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         mv         <= sms_pkg::MV_NONE;
         o_dir      <= 1'b1;
         inc_target <= '0;
      end
      else if (refuse) mv <= sms_pkg::MV_NONE;
      else if (start_jog)
      begin
         mv    <= sms_pkg::MV_JOG;
         o_dir <= rise[0];
      end
      else if (start_inc)
      begin
         mv         <= sms_pkg::MV_INC;
         o_dir      <= rise[2];
         inc_target <= inc_tgt;
      end
      else if (start_hom)
      begin
         mv    <= sms_pkg::MV_HOME;
         o_dir <= i_home_dir;
      end
      else if (start_dir)
      begin
         mv    <= sms_pkg::MV_DIR;
         o_dir <= !sp_neg;
      end
      else if (mv_end)
         mv <= sms_pkg::MV_NONE;
      else if (sign_flip && o_step_freq == '0)
         o_dir <= !sp_neg;
   end
   // Frequency, phase, position and step pulse
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_step_freq <= '0;
         phase       <= '0;
         o_position  <= '0;
         o_step      <= 1'b0;
      end
      else
      begin
         o_step_freq <= next_freq;
         phase       <= next_phase;
         o_position  <= next_pos;
         o_step      <= step_now;
      end
   end

   // Referenced state, faults and refusal reporting
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_referenced     <= 1'b0;
         o_soft_lim_fault <= 1'b0;
         o_cmd_refused_flag <= 1'b0;
         o_cmd_fault_type <= sms_pkg::FLT_NONE;
      end
      else
      begin
         if (home_done || start_fh) o_referenced <= 1'b1;
         else if ((en_q && !i_enable_cmd) || i_config_load)
            o_referenced <= 1'b0;
         // A new limit crossing wins over an acknowledge in the same cycle
         if (soft_hit) o_soft_lim_fault <= 1'b1;
         else if (i_fault_ack || !o_referenced) o_soft_lim_fault <= 1'b0;
         if (refuse)
         begin
            o_cmd_refused_flag <= 1'b1;
            o_cmd_fault_type   <= flt_code;
         end
         else if (accepted || i_fault_ack)
         begin
            o_cmd_refused_flag <= 1'b0;
            o_cmd_fault_type   <= sms_pkg::FLT_NONE;
         end
      end
   end

   // Status outputs, registered so they trail their cause by one cycle
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_done                <= 1'b1;
         o_translator_enable   <= 1'b0;
         o_axis_no_block_fault <= 1'b0;
         o_manual_mode_active  <= 1'b0;
         o_direct_mode_active  <= 1'b0;
         o_direct_motion_busy  <= 1'b0;
      end
      else
      begin
         o_done                <= (mv == sms_pkg::MV_NONE) && (next_freq == '0) && !accepted;
         o_translator_enable   <= i_enable_cmd;
         o_axis_no_block_fault <= !i_block_fault;
         o_manual_mode_active  <= (st == sms_pkg::SMS_MANUAL);
         o_direct_mode_active  <= (st == sms_pkg::SMS_DIRECT);
         o_direct_motion_busy  <= (mv == sms_pkg::MV_DIR);
      end
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   jog_release_a: assert property ((mv == sms_pkg::MV_JOG) && !jog_held
      |=> mv == sms_pkg::MV_NONE) else $error("jog outlived its command");
   jog_start_a: assert property (rise[0] && jog_ok
      |=> mv == sms_pkg::MV_JOG && o_dir) else $error("jog plus not started");
   speed_clamp_a: assert property ((mv != sms_pkg::MV_NONE)
      |=> o_step_freq <= $past(i_max_axis_freq)) else $error("speed above maximum");
   inc_unref_a: assert property ((rise[2] || rise[3]) && !o_referenced
      |=> mv != sms_pkg::MV_INC) else $error("increment while unreferenced");
   forced_home_a: assert property (start_fh |=> o_referenced
      && o_position == $past(i_shared_dword_a) && o_step_freq == '0)
      else $error("forced home wrong");
   direct_flag_a: assert property (st == sms_pkg::SMS_DIRECT
      |=> o_direct_mode_active) else $error("direct status missing");
   switch_rest_a: assert property (st == sms_pkg::SMS_SWITCH && !at_rest
      |=> st == sms_pkg::SMS_SWITCH) else $error("mode left while moving");
   busy_flag_a: assert property ((mv == sms_pkg::MV_DIR)
      |=> o_direct_motion_busy ##1 (o_direct_motion_busy || mv != sms_pkg::MV_DIR))
      else $error("direct busy wrong");
   ref_loss_a: assert property ($fell(i_enable_cmd) && !home_done && !start_fh
      |=> !o_referenced) else $error("reference kept after enable drop");
   refuse_stop_a: assert property (refuse |=> o_cmd_refused_flag
      && mv == sms_pkg::MV_NONE && o_step_freq == '0)
      else $error("refusal not reported");
   jog_run_c: cover property (start_jog ##[1:50] mv == sms_pkg::MV_NONE);
   home_run_c: cover property (start_hom ##[1:1000] home_done);
   direct_run_c: cover property (start_dir ##1 o_direct_motion_busy);
   refuse_c: cover property (refuse_d);
endmodule // sms_axis_seq
`default_nettype wire

// file: test/sms_axis_partner.sv
// Translator and axis mechanics model: counts steps, closes the home cam
`default_nettype none
module sms_axis_partner (
   input  wire logic               i_ref_clk,
   input  wire logic               i_reset,
   input  wire logic               i_enable,
   input  wire logic               i_step,
   input  wire logic               i_dir,
   input  wire logic signed [31:0] i_home_at,
   output logic signed [31:0]      o_count,
   output logic                    o_home_switch
);
   timeunit 1ns;
   timeprecision 1ps;
   // A disabled translator drops step pulses, so the axis stays put
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
         o_count <= '0;
      else if (i_step && i_enable)
         o_count <= i_dir ? o_count + 1 : o_count - 1;
   end
   // Cam closes once the axis has reached or passed the chosen spot
   assign o_home_switch = (o_count >= i_home_at);
endmodule // sms_axis_partner
`default_nettype wire

// file: test/stepper_axis_mode_sequencer_tb.sv
// Self-checking bench for the stepper axis mode sequencer
`default_nettype none
module stepper_axis_mode_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = 4;
   logic i_ref_clk = 1'b0, i_reset = 1'b1, i_plc_stop = 1'b0, i_config_load = 1'b0;
   logic i_jog_plus_cmd = 1'b0, i_jog_minus_cmd = 1'b0, i_inc_plus_cmd = 1'b0;
   logic i_inc_minus_cmd = 1'b0, i_homing_move_cmd = 1'b0, i_forced_home_cmd = 1'b0;
   logic i_direct_drive_cmd = 1'b0, i_stop_cmd = 1'b0, i_enable_cmd = 1'b1, i_fault_ack = 1'b0;
   logic i_block_fault = 1'b0, i_limit_plus = 1'b0, i_limit_minus = 1'b0, i_home_dir = 1'b1;
   logic i_home_switch;
   logic [15:0] i_mode_sel = 16'h0000, i_speed_scale_coef = 16'h0100;
   logic [23:0] i_manual_speed = 24'h01_86A0, i_max_axis_freq = 24'h03_0D40;
   logic [23:0] i_start_stop_freq = 24'h00_03E8, i_accel_step = 24'h00_1F40;
   logic signed [31:0] i_shared_dword_a = '0, i_home_value = '0, home_at = 32'h7FFF_FFFF;
   logic signed [31:0] i_soft_lim_hi = 32'h0001_86A0, i_soft_lim_lo = -32'sh0001_86A0;
   logic o_translator_enable, o_step, o_dir, o_done, o_referenced, o_axis_no_block_fault;
   logic o_soft_lim_fault, o_manual_mode_active, o_direct_mode_active, o_direct_motion_busy;
   logic o_cmd_refused_flag;
   logic [23:0] o_step_freq;
   logic [15:0] o_cmd_fault_type;
   logic signed [31:0] o_position, count, p;
   int errors = 0, comparisons = 0;
   // Short ramp tick keeps the run brief
   sms_axis_seq #(.TICK_CYC(TK)) dut (.i_ref_clk, .i_reset, .i_mode_sel, .i_plc_stop,
      .i_config_load, .i_jog_plus_cmd, .i_jog_minus_cmd, .i_inc_plus_cmd, .i_inc_minus_cmd,
      .i_homing_move_cmd, .i_forced_home_cmd, .i_direct_drive_cmd, .i_stop_cmd, .i_enable_cmd,
      .i_fault_ack, .i_block_fault, .i_limit_plus, .i_limit_minus, .i_home_switch, .i_home_dir,
      .i_manual_speed, .i_speed_scale_coef, .i_max_axis_freq, .i_start_stop_freq,
      .i_accel_step, .i_shared_dword_a, .i_home_value, .i_soft_lim_hi, .i_soft_lim_lo,
      .o_translator_enable, .o_step, .o_dir, .o_step_freq, .o_position, .o_done,
      .o_referenced, .o_axis_no_block_fault, .o_soft_lim_fault, .o_manual_mode_active,
      .o_direct_mode_active, .o_direct_motion_busy, .o_cmd_refused_flag, .o_cmd_fault_type);
   sms_axis_partner model (.i_ref_clk, .i_reset, .i_enable(o_translator_enable),
      .i_step(o_step), .i_dir(o_dir), .i_home_at(home_at), .o_count(count),
      .o_home_switch(i_home_switch));
   always #12.5 i_ref_clk = ~i_ref_clk;
   // Inputs change on the falling edge, away from the sampling edge
   task automatic cyc(input int n);
      repeat (n) @(negedge i_ref_clk);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Bounded wait, so a stuck move shows up as a mismatch
   task automatic wait_done();
      int n = 0;
      while (o_done !== 1'b1 && n < 5000)
      begin
         n++;
         cyc(1);
      end
      // One more cycle lets the model count a step launched on the last edge
      cyc(1);
      chk(32'(o_done), 32'h0000_0001);
   endtask
   task automatic ack();
      i_fault_ack = 1'b1;
      cyc(1);
      i_fault_ack = 1'b0;
      cyc(1);
   endtask
   // Scaled manual speed in 8.8, clamped at the axis maximum
   function automatic logic [23:0] jog_spd(input logic [23:0] ms, input logic [15:0] cf,
                                           input logic [23:0] mx);
      logic [39:0] s;
      s = (40'(ms) * 40'(cf)) >> 8;
      return (s > 40'(mx)) ? mx : s[23:0];
   endfunction
   task automatic close_out();
      $display("comparisons=%0d errors=%0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Watchdog: the tests need well under a third of this span
   initial
   begin
      repeat (30000) @(posedge i_ref_clk);
      errors++;
      close_out();
   end
   // Main sequence
   initial
   begin
      void'($urandom(32'h009d_66d7));
      i_manual_speed = 24'h01_86A0 + 24'($urandom % 150000);
      i_speed_scale_coef = 16'h0080 + 16'($urandom % 256);
      cyc(6);
      i_reset = 1'b0;
      cyc(2);
      chk(32'({o_done, o_manual_mode_active, o_axis_no_block_fault}), 32'h0000_0005);
      i_jog_plus_cmd = 1'b1;
      cyc(4);
      chk(32'(o_done), 32'h0000_0001);
      // Jog bit already high on entry must be ignored
      i_mode_sel = 16'h0002;
      cyc(6);
      chk(32'(o_manual_mode_active), 32'h0000_0001);
      chk(32'(o_done), 32'h0000_0001);
      i_jog_plus_cmd = 1'b0;
      cyc(1);
      i_jog_plus_cmd = 1'b1;
      cyc(3);
      chk(32'({o_done, o_dir}), 32'h0000_0001);
      cyc(300);
      i_speed_scale_coef = 16'h0080 + 16'($urandom % 256);
      cyc(300);
      p = 32'(jog_spd(i_manual_speed, i_speed_scale_coef, i_max_axis_freq));
      chk(32'(o_step_freq), p);
      i_jog_plus_cmd = 1'b0;
      cyc(3);
      wait_done();
      chk(o_position, count);
      // Increment refused while the axis is unreferenced
      i_inc_plus_cmd = 1'b1;
      cyc(2);
      chk(32'({o_cmd_refused_flag, o_cmd_fault_type}), 32'h0001_0002);
      i_inc_plus_cmd = 1'b0;
      ack();
      p = $signed(32'($urandom % 2001)) - 1000;
      i_shared_dword_a = p;
      i_forced_home_cmd = 1'b1;
      cyc(1);
      i_forced_home_cmd = 1'b0;
      cyc(2);
      chk(o_position, p);
      chk(32'({o_referenced, o_done, o_soft_lim_fault}), 32'h0000_0006);
      // Increments both ways, the amount loaded before the edge
      i_shared_dword_a = 32'h0000_0003;
      i_inc_plus_cmd = 1'b1;
      cyc(1);
      i_inc_plus_cmd = 1'b0;
      cyc(3);
      wait_done();
      chk(o_position, p + 3);
      i_inc_minus_cmd = 1'b1;
      cyc(1);
      i_inc_minus_cmd = 1'b0;
      cyc(3);
      wait_done();
      chk(o_position, p);
      i_shared_dword_a = 32'h0003_0D40;
      i_inc_plus_cmd = 1'b1;
      cyc(2);
      chk(32'({o_cmd_refused_flag, o_cmd_fault_type}), 32'h0001_0004);
      i_inc_plus_cmd = 1'b0;
      ack();
      // Homing stops at the cam and loads the home value
      home_at = count + 2;
      i_home_value = $signed(32'($urandom % 5000));
      i_homing_move_cmd = 1'b1;
      cyc(1);
      i_homing_move_cmd = 1'b0;
      cyc(3);
      wait_done();
      // Steps after the cam still count on both sides while the axis slows down
      chk(o_position - i_home_value, count - home_at);
      chk(32'(o_referenced), 32'h0000_0001);
      home_at = 32'h7FFF_FFFF;
      // Dropping enable loses the reference
      i_enable_cmd = 1'b0;
      cyc(3);
      chk(32'({o_referenced, o_translator_enable}), 32'h0000_0000);
      i_enable_cmd = 1'b1;
      i_mode_sel = 16'h0001;
      cyc(6);
      chk(32'({o_direct_mode_active, o_manual_mode_active}), 32'h0000_0002);
      i_shared_dword_a = 32'h0003_0D41;
      i_direct_drive_cmd = 1'b1;
      cyc(2);
      chk(32'({o_cmd_refused_flag, o_cmd_fault_type}), 32'h0001_0100);
      i_direct_drive_cmd = 1'b0;
      ack();
      // Setpoint sign flips mid-run; ramps through zero to the new speed
      p = -$signed(32'(1000 + $urandom % 150000));
      i_shared_dword_a = p;
      i_direct_drive_cmd = 1'b1;
      cyc(300);
      chk(32'({o_direct_motion_busy, o_dir}), 32'h0000_0002);
      chk(32'(o_step_freq), -p);
      i_shared_dword_a = -p;
      cyc(300);
      chk(32'({o_dir, o_step_freq}), 32'h0100_0000 | -p);
      chk(32'(o_step_freq >= i_start_stop_freq), 32'h0000_0001);
      chk(32'(o_step_freq <= i_max_axis_freq), 32'h0000_0001);
      i_stop_cmd = 1'b1;
      cyc(3);
      wait_done();
      chk(32'(o_direct_motion_busy), 32'h0000_0000);
      i_stop_cmd = 1'b0;
      i_direct_drive_cmd = 1'b0;
      cyc(2);
      i_jog_minus_cmd = 1'b1;
      cyc(2);
      chk(32'({o_cmd_refused_flag, o_cmd_fault_type}), 32'h0001_0008);
      i_jog_minus_cmd = 1'b0;
      ack();
      i_mode_sel = 16'h0000;
      cyc(6);
      chk(32'({o_direct_mode_active, o_manual_mode_active}), 32'h0000_0000);
      close_out();
   end
endmodule // stepper_axis_mode_sequencer_tb
`default_nettype wire
